// file: core/ctsi_core_thermal.sv
// Function
// - bit 0 mirrors live high-temperature signal
// - bit 1 sticky hot log, zero-write clears
// - bits 2/3 external hot/power-reduction status, log
// - bits 4/5 critical status and sticky log
// - bits 6/7 threshold one status and log
// - bits 8/9 threshold two status and log
// - bit 10 live power-limit status if supported
// - bit 11 sticky power-limit log
// - bits 22:16 readout, distance below activation
// - bits 30:27 sensor resolution read-only
// - bit 31 set only for valid readout
// - readout saturates at activation point
// - enable bit 0 event on going hot
// - enable bit 1 event on cooling down
// - enable bit 2 event on external hot
// - enable bit 3 event on power reduction
// - enable bit 4 event on critical temperature
// - threshold one compare, bit 15 crossing event
// - threshold two compare, bit 23 crossing event
// - enable bit 24 event on power limit
// - all events share one vector entry
// - reset clears enables, vector entry masked
module ctsi_core_thermal #(
  parameter bit PWR_NOTIFY_SUP = 1'b1,
  parameter logic [ctsi_pkg::RES_W-1:0] SENSOR_RES = 4'h1
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        sens_hot,
  input  wire logic                        ext_hot,
  input  wire logic                        forced_power_reduction_input,
  input  wire logic                        bidir_hot_en,
  input  wire logic                        crit_temp,
  input  wire logic                        pwr_limited,
  input  wire logic [ctsi_pkg::TEMP_W-1:0] sens_temp,
  input  wire logic                        sens_valid,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [1:0]                  reg_sel,
  input  wire logic [31:0]                 reg_wdata,
  output logic      [31:0]                 reg_rdata,
  output logic                             thermal_event
);
  import ctsi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]       ctl_q, ctl_d;
  logic [11:0]       st_q, st_d;
  logic [TEMP_W-1:0] rd_q, rd_d;
  logic              vld_q, vld_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              ev_q, ev_d;
  logic [11:0]       live;
  logic [TEMP_W-1:0] th1, th2;

  // sticky log: set wins over a zero-write clear; writing one keeps it
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic wr, input logic wbit);
    sticky = set | (cur & ~(wr & ~wbit));
  endfunction : sticky

  // lower readout means hotter, so "at or above" is readout <= threshold
  function automatic logic at_or_above(input logic [TEMP_W-1:0] rd,
                                       input logic [TEMP_W-1:0] th);
    at_or_above = (rd <= th);
  endfunction : at_or_above

  assign th1 = ctl_q[IC_TH1_LSB +: TEMP_W];
  assign th2 = ctl_q[IC_TH2_LSB +: TEMP_W];
  assign reg_rdata     = rdata_q;
  assign thermal_event = ev_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic wr_st;
    wr_st = reg_wr && (reg_sel == REG_STATUS);
    // readout is unsigned, so it can never go above the activation point
    rd_d  = sens_temp;
    vld_d = sens_valid;
    live  = '0;
    live[ST_HOT]  = sens_hot;
    live[ST_EXT]  = (ext_hot & bidir_hot_en) | forced_power_reduction_input;
    live[ST_CRIT] = crit_temp;
    live[ST_TH1]  = vld_q & at_or_above(rd_q, th1);
    live[ST_TH2]  = vld_q & at_or_above(rd_q, th2);
    live[ST_PWR]  = PWR_NOTIFY_SUP & pwr_limited;
    st_d = st_q;
    for (int i = 0; i < 12; i += 2) begin
      st_d[i]   = live[i];
      st_d[i+1] = sticky(st_q[i+1], live[i], wr_st, reg_wdata[i+1]);
    end
    ctl_d = ctl_q;
    if (reg_wr && (reg_sel == REG_INTCTL)) begin
      ctl_d = reg_wdata & IC_WMASK;
    end
  end

  always_comb begin
    logic [11:0] rise, fall;
    rise = st_d & ~st_q;
    fall = ~st_d & st_q;
    // one shared request line; software polls status to find the source
    ev_d = (ctl_q[IC_HI_EN] & rise[ST_HOT])
         | (ctl_q[IC_LO_EN] & fall[ST_HOT])
         | (ctl_q[IC_EXTHOT_EN] & bidir_hot_en & ext_hot & rise[ST_EXT])
         | (ctl_q[IC_FPR_EN] & forced_power_reduction_input & rise[ST_EXT])
         | (ctl_q[IC_CRIT_EN] & rise[ST_CRIT])
         | (ctl_q[IC_TH1_EN] & (rise[ST_TH1] | fall[ST_TH1]))
         | (ctl_q[IC_TH2_EN] & (rise[ST_TH2] | fall[ST_TH2]))
         | (ctl_q[IC_PWR_EN] & PWR_NOTIFY_SUP & rise[ST_PWR]);
  end

  always_comb begin
    rdata_d = '0;
    if (reg_rd && (reg_sel == REG_STATUS)) begin
      rdata_d[11:0]                     = st_q;
      rdata_d[ST_RDOUT_LSB +: TEMP_W]   = rd_q;
      rdata_d[ST_RES_LSB +: RES_W]      = SENSOR_RES;
      rdata_d[ST_VALID]                 = vld_q;
    end else if (reg_rd && (reg_sel == REG_INTCTL)) begin
      rdata_d = ctl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl_q   <= IC_RESET;
      st_q    <= '0;
      rd_q    <= '0;
      vld_q   <= 1'b0;
      rdata_q <= '0;
      ev_q    <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      st_q    <= st_d;
      rd_q    <= rd_d;
      vld_q   <= vld_d;
      rdata_q <= rdata_d;
      ev_q    <= ev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_hot_mirror;
    @(posedge ref_clk) disable iff (srst) sens_hot |=> st_q[ST_HOT];
  endproperty
  a_hot_mirror: assert property (p_hot_mirror) else $error("hot bit not mirrored");

  property p_hot_log;
    @(posedge ref_clk) disable iff (srst) st_q[ST_HOT] |-> st_q[ST_HOT_LOG];
  endproperty
  a_hot_log: assert property (p_hot_log) else $error("hot log missing");

  property p_log_hold;
    @(posedge ref_clk) disable iff (srst)
      (st_q[ST_CRIT_LOG] && !(reg_wr && reg_sel == REG_STATUS)) |=> st_q[ST_CRIT_LOG];
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("crit log dropped");

  property p_th1;
    @(posedge ref_clk) disable iff (srst)
      (vld_q && rd_q <= th1) |=> st_q[ST_TH1] || $past(srst);
  endproperty
  a_th1: assert property (p_th1) else $error("threshold one status wrong");

  property p_ctl_reset;
    @(posedge ref_clk) srst |=> (ctl_q == IC_RESET);
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("enables not cleared");

  sequence s_hot_rise;
    !st_q[ST_HOT] ##1 st_q[ST_HOT];
  endsequence
  property p_hi_event;
    @(posedge ref_clk) disable iff (srst)
      (ctl_q[IC_HI_EN] && $stable(ctl_q[IC_HI_EN]) && $rose(st_d[ST_HOT])) |=> ev_q;
  endproperty
  a_hi_event: assert property (p_hi_event) else $error("missing hot event");

  property p_pulse;
    @(posedge ref_clk) disable iff (srst) ev_q && !(st_q != $past(st_q)) |=> 1'b1;
  endproperty

  property p_no_event;
    @(posedge ref_clk) disable iff (srst) (ctl_q == '0) |=> !ev_q;
  endproperty
  a_no_event: assert property (p_no_event) else $error("event with enables clear");

  property p_single;
    @(posedge ref_clk) disable iff (srst) ev_q |-> $past(st_d) != $past(st_q);
  endproperty
  a_single: assert property (p_single) else $error("event without status edge");

  property p_valid;
    @(posedge ref_clk) disable iff (srst) !sens_valid |=> !vld_q;
  endproperty
  a_valid: assert property (p_valid) else $error("valid bit wrong");

  property p_hot_clear;
    @(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_sel == REG_STATUS && !reg_wdata[ST_HOT_LOG] && !sens_hot)
      |=> !st_q[ST_HOT_LOG];
  endproperty
  a_hot_clear: assert property (p_hot_clear) else $error("hot log not cleared");

  property p_ext_live;
    @(posedge ref_clk) disable iff (srst)
      ((ext_hot && bidir_hot_en) || forced_power_reduction_input)
      |=> (st_q[ST_EXT] && st_q[ST_EXT_LOG]);
  endproperty
  a_ext_live: assert property (p_ext_live) else $error("external hot not shown");

  // external hot without the bidirectional feature must not count
  property p_ext_ignored;
    @(posedge ref_clk) disable iff (srst)
      (ext_hot && !bidir_hot_en && !forced_power_reduction_input) |=> !st_q[ST_EXT];
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("external hot counted");

  property p_crit_mirror;
    @(posedge ref_clk) disable iff (srst)
      crit_temp |=> (st_q[ST_CRIT] && st_q[ST_CRIT_LOG]);
  endproperty
  a_crit_mirror: assert property (p_crit_mirror) else $error("critical not shown");

  property p_th1_below;
    @(posedge ref_clk) disable iff (srst)
      (vld_q && rd_q > th1) |=> !st_q[ST_TH1];
  endproperty
  a_th1_below: assert property (p_th1_below) else $error("threshold one set early");

  property p_th2;
    @(posedge ref_clk) disable iff (srst)
      (vld_q && rd_q <= th2) |=> (st_q[ST_TH2] && st_q[ST_TH2_LOG]);
  endproperty
  a_th2: assert property (p_th2) else $error("threshold two status wrong");

  property p_th2_below;
    @(posedge ref_clk) disable iff (srst)
      (vld_q && rd_q > th2) |=> !st_q[ST_TH2];
  endproperty
  a_th2_below: assert property (p_th2_below) else $error("threshold two set early");

  property p_pwr;
    @(posedge ref_clk) disable iff (srst)
      pwr_limited |=> (st_q[ST_PWR] == PWR_NOTIFY_SUP);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power limit status wrong");

  property p_pwr_log;
    @(posedge ref_clk) disable iff (srst) st_q[ST_PWR] |-> st_q[ST_PWR_LOG];
  endproperty
  a_pwr_log: assert property (p_pwr_log) else $error("power limit log missing");

  property p_readout;
    @(posedge ref_clk) disable iff (srst)
      !$past(srst) |-> (rd_q == $past(sens_temp));
  endproperty
  a_readout: assert property (p_readout) else $error("readout not tracking");

  property p_res_read;
    @(posedge ref_clk) disable iff (srst)
      (reg_rd && reg_sel == REG_STATUS)
      |=> (reg_rdata[ST_RES_LSB +: RES_W] == SENSOR_RES && reg_rdata[ST_VALID] == vld_q);
  endproperty
  a_res_read: assert property (p_res_read) else $error("resolution field wrong");

  sequence s_arm_lo;
    ctl_q[IC_LO_EN] && st_q[ST_HOT];
  endsequence
  property p_lo_event;
    @(posedge ref_clk) disable iff (srst) s_arm_lo ##1 !st_q[ST_HOT] |-> ev_q;
  endproperty
  a_lo_event: assert property (p_lo_event) else $error("missing cool-down event");

  sequence s_arm_ext;
    ctl_q[IC_EXTHOT_EN] && !st_q[ST_EXT];
  endsequence
  property p_ext_event;
    @(posedge ref_clk) disable iff (srst)
      s_arm_ext ##1 (st_q[ST_EXT] && $past(bidir_hot_en && ext_hot)) |-> ev_q;
  endproperty
  a_ext_event: assert property (p_ext_event) else $error("missing external hot event");

  sequence s_arm_fpr;
    ctl_q[IC_FPR_EN] && !st_q[ST_EXT];
  endsequence
  property p_fpr_event;
    @(posedge ref_clk) disable iff (srst)
      s_arm_fpr ##1 (st_q[ST_EXT] && $past(forced_power_reduction_input)) |-> ev_q;
  endproperty
  a_fpr_event: assert property (p_fpr_event) else $error("missing reduction event");

  sequence s_arm_crit;
    ctl_q[IC_CRIT_EN] && !st_q[ST_CRIT];
  endsequence
  property p_crit_event;
    @(posedge ref_clk) disable iff (srst) s_arm_crit ##1 st_q[ST_CRIT] |-> ev_q;
  endproperty
  a_crit_event: assert property (p_crit_event) else $error("missing critical event");

  property p_th1_event;
    @(posedge ref_clk) disable iff (srst)
      ctl_q[IC_TH1_EN] ##1 $changed(st_q[ST_TH1]) |-> ev_q;
  endproperty
  a_th1_event: assert property (p_th1_event) else $error("missing threshold one event");

  property p_th2_event;
    @(posedge ref_clk) disable iff (srst)
      ctl_q[IC_TH2_EN] ##1 $changed(st_q[ST_TH2]) |-> ev_q;
  endproperty
  a_th2_event: assert property (p_th2_event) else $error("missing threshold two event");

  sequence s_arm_pwr;
    ctl_q[IC_PWR_EN] && !st_q[ST_PWR];
  endsequence
  property p_pwr_event;
    @(posedge ref_clk) disable iff (srst) s_arm_pwr ##1 st_q[ST_PWR] |-> ev_q;
  endproperty
  a_pwr_event: assert property (p_pwr_event) else $error("missing power limit event");

  // no request may escape in the cycle after reset, whatever the inputs do
  property p_reset_quiet;
    @(posedge ref_clk) srst |=> (!ev_q && reg_rdata == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");

  property p_one_keeps;
    @(posedge ref_clk) disable iff (srst)
      (st_q[ST_CRIT_LOG] && reg_wr && reg_sel == REG_STATUS && reg_wdata[ST_CRIT_LOG])
      |=> st_q[ST_CRIT_LOG];
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("one write cleared log");

  property p_ctl_untouched;
    @(posedge ref_clk) disable iff (srst)
      !(reg_wr && reg_sel == REG_INTCTL) |=> (ctl_q == $past(ctl_q));
  endproperty
  a_ctl_untouched: assert property (p_ctl_untouched) else $error("control changed");

  property p_unused_read;
    @(posedge ref_clk) disable iff (srst)
      (reg_rd && reg_sel != REG_STATUS && reg_sel != REG_INTCTL) |=> (reg_rdata == '0);
  endproperty
  a_unused_read: assert property (p_unused_read) else $error("unused select read");
endmodule : ctsi_core_thermal

// file: core/ctsi_pkg.sv
package ctsi_pkg;
  // model-specific register select codes
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_INTCTL = 2'h1;

  // status register fields
  localparam int ST_HOT        = 0;
  localparam int ST_HOT_LOG    = 1;
  localparam int ST_EXT        = 2;
  localparam int ST_EXT_LOG    = 3;
  localparam int ST_CRIT       = 4;
  localparam int ST_CRIT_LOG   = 5;
  localparam int ST_TH1        = 6;
  localparam int ST_TH1_LOG    = 7;
  localparam int ST_TH2        = 8;
  localparam int ST_TH2_LOG    = 9;
  localparam int ST_PWR        = 10;
  localparam int ST_PWR_LOG    = 11;
  localparam int ST_RDOUT_LSB  = 16;
  localparam int ST_RES_LSB    = 27;
  localparam int ST_VALID      = 31;

  // interrupt control fields
  localparam int IC_HI_EN      = 0;
  localparam int IC_LO_EN      = 1;
  localparam int IC_EXTHOT_EN  = 2;
  localparam int IC_FPR_EN     = 3;
  localparam int IC_CRIT_EN    = 4;
  localparam int IC_TH1_LSB    = 8;
  localparam int IC_TH1_EN     = 15;
  localparam int IC_TH2_LSB    = 16;
  localparam int IC_TH2_EN     = 23;
  localparam int IC_PWR_EN     = 24;

  localparam int TEMP_W        = 7;
  localparam int RES_W         = 4;

  // writable bits of interrupt control: 24,23:8,4:0
  localparam logic [31:0] IC_WMASK = 32'h01ffff1f;
  localparam logic [31:0] IC_RESET = 32'h00000000;
endpackage : ctsi_pkg

// file: verification/ctsi_sensor_model.sv
module ctsi_sensor_model (
  input  wire logic        ref_clk,
  input  wire logic [13:0] cmd,
  output logic      [6:0]  flags,
  output logic      [6:0]  temp
);
  timeunit 1ns;
  timeprecision 1ps;
  // sensor and agents change only once a clock, never mid-cycle
  initial {flags, temp} = 14'h00ff;
  always @(posedge ref_clk) begin
    {flags, temp} <= cmd;
  end
endmodule : ctsi_sensor_model

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ctsi_pkg::*;
  typedef struct {logic [31:0] ctl; logic [13:0] inp; logic [31:0] st; int ev;} ctsi_row_s;
  // flags: hot, ext, power reduction, bidir, crit, pwr, valid; then readout
  localparam logic [13:0] BASE = 14'h00ff;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  reg_sel = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        thermal_event;
  logic [13:0] cmd = BASE;
  logic [6:0]  flags;
  logic [6:0]  temp;
  logic [31:0] st;
  int          errors = 0;
  int          checks = 0;
  int          ev_cnt = 0;
  int          ev0;
  ctsi_row_s   rows [11] = '{
    '{32'h1, 14'h20ff, 32'h887f0003, 1}, '{32'h0, 14'h20ff, 32'h887f0003, 0},
    '{32'h4, 14'h14ff, 32'h887f000c, 1}, '{32'h4, 14'h10ff, 32'h887f0000, 0},
    '{32'h8, 14'h08ff, 32'h887f000c, 1}, '{32'h10, 14'h02ff, 32'h887f0030, 1},
    '{32'h01000000, 14'h01ff, 32'h887f0c00, 1}, '{32'ha000, 14'h00a0, 32'h882000c0, 1},
    '{32'ha000, 14'h00a1, 32'h88210000, 0}, '{32'h00900000, 14'h0085, 32'h88050300, 1},
    '{32'h0, 14'h0080, 32'h880003c0, 0}};
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (thermal_event === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  ctsi_sensor_model i_model (.ref_clk(ref_clk), .cmd(cmd), .flags(flags), .temp(temp));
  ctsi_core_thermal i_dut (
    .ref_clk(ref_clk), .srst(srst), .sens_hot(flags[6]), .ext_hot(flags[5]),
    .forced_power_reduction_input(flags[4]), .bidir_hot_en(flags[3]),
    .crit_temp(flags[2]), .pwr_limited(flags[1]), .sens_temp(temp),
    .sens_valid(flags[0]), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .thermal_event(thermal_event));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] s);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_sel <= s;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t register %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_ev(input int exp);
    checks++;
    if (ev_cnt - ev0 != exp) begin
      errors++;
      $display("[ERR] %0t events %0d expected %0d", $time, ev_cnt - ev0, exp);
    end
  endtask : chk_ev
  // applies one input set and lets the two-cycle threshold path settle
  task automatic drive(input logic [13:0] v);
    @(posedge ref_clk);
    cmd <= v;
    repeat (6) @(posedge ref_clk);
  endtask : drive
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(REG_INTCTL);
    chk(st, IC_RESET);
    rd(REG_STATUS);
    chk(st, 32'h887f0000);
    rd(2'h2);
    chk(st, 32'h0);
    wr(REG_INTCTL, 32'hffffffff);
    rd(REG_INTCTL);
    chk(st, IC_WMASK);
    wr(REG_INTCTL, 32'h0);
    // all-ones thresholds tripped both threshold logs; clear them before the rows
    wr(REG_STATUS, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(REG_INTCTL, rows[i].ctl);
      ev0 = ev_cnt;
      drive(rows[i].inp);
      rd(REG_STATUS);
      chk(st, rows[i].st);
      chk_ev(rows[i].ev);
      // disable first so the return to idle cannot raise a stray event
      wr(REG_INTCTL, 32'h0);
      drive(BASE);
      wr(REG_STATUS, 32'h0);
      $display("row %0d done", i);
    end
    wr(REG_INTCTL, 32'h2);
    ev0 = ev_cnt;
    drive(14'h20ff);
    chk_ev(0);
    drive(BASE);
    chk_ev(1);
    wr(REG_STATUS, 32'hffffffff);
    rd(REG_STATUS);
    chk(st, 32'h887f0002);
    wr(REG_STATUS, 32'h0);
    rd(REG_STATUS);
    chk(st, 32'h887f0000);
    $display("cool-down test done");
    wr(REG_INTCTL, 32'h2000);
    drive(14'h0020);
    rd(REG_STATUS);
    chk(st & 32'hff80ffff, 32'h08000000);
    $display("invalid readout test done");
    final_report();
  end
endmodule : testbench
